// ===== shared/ddc_defs.svh
// constants of the display data channel slave
//
// Functional notes
// RULE1: no access bit, unit off: buffer locked, no interrupts, no activity, space unmapped.
// RULE2: no access bit, unit on: automatic mode, buffer owned by channel hardware only.
// RULE3: access bit set, unit off: software reaches buffer, no interrupts or activity.
// RULE4: access bit set, unit on: manual mode, byte interrupts, byte held in data register.
// RULE5: unit counts as enabled when legacy enable or two-wire enable is set.
// RULE6: classify the attached host as legacy, basic two-wire or extended two-wire.
// RULE7: legacy mode only transmits toward the host, never receives.
// RULE8: first nine vertical-sync clocks are used for synchronisation before data.
// RULE9: serial data stays released during the legacy synchronisation period.
// RULE10: software loads buffer with access bit, then clears it, zeroes pointer, enables.
// RULE11: legacy enable is clear after power-on reset.
// RULE12: software access bit resets to zero.
// RULE13: vertical sync up to 25 kHz accepted; ninth clock of each byte interrupts.
// RULE14: at 40 MHz the manual-mode service routine finishes within 133 machine cycles.
// RULE15: small buffer: legacy uses lower half, post-increment only there.
// RULE16: in two-wire mode the unit is always slave, direction set by host.
// RULE17: two-wire transfers use the buffer address pointer.
// RULE18: default slave addresses are a0 for writes and a1 for reads.
// RULE19: serial clock is held low while software or buffer cannot keep up.
// RULE20: two-wire transfers work as single bytes and as bursts.
// RULE21: pointer increments after each buffer window access by software or legacy logic.
// RULE22: switching to two-wire mode sets a flag; mode sticks until disabled or reset.
// RULE23: any-address option ignores the three low slave address bits.
// RULE24: legacy manual mode sets the legacy byte flag on ninth clock; software clears.
// RULE25: valid two-wire start from the host moves the unit into two-wire mode.
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_SYNC_CLKS   4'd9
`define DDC_BIT_STOP    4'd8
`define DDC_I2C_BITS    4'd8
`define DDC_SLAVE_ADDR  7'h50
`define ANY_ADDRESS_MATCH_MASK     7'h78
`define DDC_PTR_RESET   8'h00
`define DDC_DATA_RESET  8'h00
`define DDC_FIFO_DEPTH  16
`define DDC_FIFO_WIDTH  16
`endif

// ===== shared/ddc_pkg.sv
// types of the display data channel slave
package ddc_pkg;
   typedef enum logic [3:0] {
      DDC_I_IDLE, DDC_I_ADDR, DDC_I_ADDR_ACK, DDC_I_WDATA, DDC_I_WHOLD,
      DDC_I_WACK, DDC_I_RLOAD, DDC_I_RDATA, DDC_I_RACK
   } ddc_i2c_e;
   typedef enum logic [1:0] {
      DDC_HOST_NONE, DDC_HOST_LEGACY, DDC_HOST_BASIC, DDC_HOST_EXT
   } ddc_host_e;
endpackage

// ===== core/ddc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ddc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [CW-1:0]    cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != CW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
         end
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end
endmodule
`default_nettype wire

// ===== core/ddc_slave.sv
// display data channel slave: legacy transmitter, two-wire slave and buffer
`timescale 1ns/100ps
`default_nettype none
`include "ddc_defs.svh"
module ddc_slave import ddc_pkg::*; #(
   parameter int         FIFO_DEPTH = `DDC_FIFO_DEPTH,
   parameter logic [6:0] SLAVE_ADDR = `DDC_SLAVE_ADDR
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // control bits
   input  wire logic       legacy_mode_enable,
   input  wire logic       two_wire_enable,
   input  wire logic       software_buffer_access,
   input  wire logic       buffer_size_select,
   input  wire logic       any_address_match,
   // software buffer port
   input  wire logic       mcu_req,
   input  wire logic       mcu_we,
   input  wire logic       mcu_use_window,
   input  wire logic [7:0] mcu_addr,
   input  wire logic [7:0] mcu_wdata,
   output logic [7:0]      mcu_rdata,
   // pointer and data register
   input  wire logic       ptr_load,
   input  wire logic [7:0] ptr_wdata,
   output logic [7:0]      buffer_address_pointer,
   input  wire logic       data_reg_load,
   input  wire logic [7:0] data_reg_wdata,
   output logic [7:0]      two_wire_data_reg,
   // flags and status
   input  wire logic       legacy_irq_clear,
   input  wire logic       mode_switch_clear,
   input  wire logic       byte_irq_clear,
   output logic            legacy_byte_irq_flag,
   output logic            mode_switch_flag,
   output logic            byte_irq_flag,
   output logic            mode_ddc2,
   output logic            buffer_space_mapped,
   output logic [1:0]      host_type,
   // pins
   input  wire logic       vsync_pin,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            scl_oe,
   output logic            sda_out,
   output logic            sda_oe
);
   logic [7:0] mem_r [256];
   logic [7:0] ptr_r;
   logic [7:0] data_r;
   logic [7:0] rdata_r;
   logic       lirq_r;
   logic       swf_r;
   logic       birq_r;
   logic       mode2_r;
   logic       mapped_r;
   ddc_host_e  host_r;
   logic       vs_s1, vs_s2, vs_s3;
   logic       scl_s1, scl_s2, scl_s3;
   logic       sda_s1, sda_s2, sda_s3;
   logic [3:0] sync_cnt_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] lsh_r;
   ddc_i2c_e   st_r;
   logic [3:0] bcnt_r;
   logic [7:0] sh_r;
   logic       rw_r;
   logic       first_r;
   logic       ack_r;
   logic       sda_lo_r;
   logic       scl_oe_r;
   logic       sda_oe_r;
   logic       sda_out_r;
   logic       scl_out_r;

   // unit state decoding
   logic enabled, auto_mode, manual_mode, legacy_active;
   assign enabled       = legacy_mode_enable | two_wire_enable; // RULE5
   assign auto_mode     = enabled & ~software_buffer_access; // RULE2
   assign manual_mode   = enabled & software_buffer_access; // RULE4
   assign legacy_active = legacy_mode_enable & ~mode2_r;

   // buffer window steps the pointer; small buffer only steps inside the lower half
   function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic big);
      if (big) begin
         ptr_next = p + 8'h01;
      end else if (!p[7]) begin
         ptr_next = {1'b0, p[6:0] + 7'h01}; // RULE15
      end else begin
         ptr_next = p;
      end
   endfunction

   function automatic logic addr_hit(input logic [6:0] a, input logic ax);
      logic [6:0] m;
      m = ax ? `ANY_ADDRESS_MATCH_MASK : 7'h7f; // RULE23
      addr_hit = ((a & m) == (SLAVE_ADDR & m)); // RULE18
   endfunction

   // pins are asynchronous to clk; edges are found only after the second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {vs_s1, vs_s2, vs_s3}    <= 3'h0;
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
      end else begin
         {vs_s1, vs_s2, vs_s3}    <= {vsync_pin, vs_s1, vs_s2};
         {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
      end
   end

   logic vs_rise, scl_rise, scl_fall, i2c_start, i2c_stop, i2c_ev;
   assign vs_rise   = vs_s2 & ~vs_s3;
   assign scl_rise  = scl_s2 & ~scl_s3;
   assign scl_fall  = ~scl_s2 & scl_s3;
   assign i2c_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign i2c_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   assign i2c_ev    = two_wire_enable & ~i2c_start & ~i2c_stop;

   // fifo carries {address, data} of bytes written by the host in automatic mode
   logic        mcu_ok, f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [15:0] f_out_data;
   assign mcu_ok      = mcu_req & software_buffer_access; // RULE1 RULE3
   assign f_out_ready = ~mcu_ok;

   // legacy byte load, two-wire events
   logic ddc1_load, whold_enter, whold_go, rload_enter, rload_go;
   logic [7:0] ddc1_byte;
   assign ddc1_load = legacy_active & vs_rise
      & ((sync_cnt_r == `DDC_SYNC_CLKS - 4'd1)
         | ((sync_cnt_r == `DDC_SYNC_CLKS) & (bit_cnt_r == `DDC_BIT_STOP))); // RULE8
   assign ddc1_byte   = software_buffer_access ? data_r : mem_r[ptr_r];
   assign whold_enter = i2c_ev & (st_r == DDC_I_WDATA) & scl_fall & (bcnt_r == `DDC_I2C_BITS);
   assign whold_go    = (st_r == DDC_I_WHOLD)
      & (first_r | (manual_mode ? ~birq_r : f_in_ready)); // RULE19
   assign f_in_valid  = (st_r == DDC_I_WHOLD) & auto_mode & ~first_r;
   assign rload_enter = i2c_ev & scl_fall
      & (((st_r == DDC_I_ADDR_ACK) & rw_r) | ((st_r == DDC_I_RACK) & ack_r));
   assign rload_go    = (st_r == DDC_I_RLOAD)
      & (manual_mode ? ~birq_r : ~f_out_valid); // RULE19

   ddc_fifo #(.WIDTH(`DDC_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   ({ptr_r, sh_r}),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // buffer storage; contents are undefined after reset
   always_ff @(posedge clk) begin
      if (mcu_ok && mcu_we) begin
         mem_r[mcu_use_window ? ptr_r : mcu_addr] <= mcu_wdata; // RULE3
      end else if (f_out_valid) begin
         mem_r[f_out_data[15:8]] <= f_out_data[7:0]; // RULE17
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= `DDC_DATA_RESET;
      end else if (mcu_ok && !mcu_we) begin
         rdata_r <= mem_r[mcu_use_window ? ptr_r : mcu_addr];
      end
   end

   // buffer address pointer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_r <= `DDC_PTR_RESET;
      end else if (ptr_load) begin
         ptr_r <= ptr_wdata;
      end else if (whold_go && first_r) begin
         ptr_r <= sh_r; // RULE17
      end else if (rload_go && auto_mode) begin
         ptr_r <= ptr_next(ptr_r, buffer_size_select); // RULE20
      end else if (ddc1_load && auto_mode) begin
         ptr_r <= ptr_next(ptr_r, buffer_size_select); // RULE21
      end else if (mcu_ok && mcu_use_window) begin
         ptr_r <= ptr_next(ptr_r, buffer_size_select); // RULE21
      end
   end

   // two-wire data register holds each manual-mode byte
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_r <= `DDC_DATA_RESET;
      end else if (whold_enter && manual_mode) begin
         data_r <= sh_r; // RULE4
      end else if (data_reg_load) begin
         data_r <= data_reg_wdata;
      end
   end

   // flags: a set in the cycle of a clear wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lirq_r <= 1'b0;
         birq_r <= 1'b0;
         swf_r  <= 1'b0;
      end else begin
         if (!enabled) begin
            lirq_r <= 1'b0; // RULE1
            birq_r <= 1'b0; // RULE3
         end else begin
            if (ddc1_load && manual_mode && sync_cnt_r == `DDC_SYNC_CLKS) begin
               lirq_r <= 1'b1; // RULE13 RULE24
            end else if (legacy_irq_clear) begin
               lirq_r <= 1'b0;
            end
            if (manual_mode && (whold_enter || rload_enter)) begin
               birq_r <= 1'b1; // RULE4
            end else if (byte_irq_clear) begin
               birq_r <= 1'b0;
            end
         end
         if (two_wire_enable && i2c_start && legacy_mode_enable && !mode2_r) begin
            swf_r <= 1'b1; // RULE22
         end else if (mode_switch_clear) begin
            swf_r <= 1'b0;
         end
      end
   end

   // mode bit sticks until the unit is disabled
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode2_r <= 1'b0;
      end else if (!enabled) begin
         mode2_r <= 1'b0; // RULE22
      end else if (two_wire_enable && i2c_start) begin
         mode2_r <= 1'b1; // RULE25
      end
   end

   // host classification, restarted whenever the unit is off
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_r <= DDC_HOST_NONE;
      end else if (!enabled) begin
         host_r <= DDC_HOST_NONE;
      end else if (whold_enter) begin
         host_r <= DDC_HOST_EXT; // RULE6
      end else if (rload_enter && host_r != DDC_HOST_EXT) begin
         host_r <= DDC_HOST_BASIC; // RULE6
      end else if (ddc1_load && host_r == DDC_HOST_NONE) begin
         host_r <= DDC_HOST_LEGACY; // RULE6
      end
   end

   // legacy transmitter: 9 sync clocks, then 8 data bits and a released ninth bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_cnt_r <= 4'h0; // RULE11
         bit_cnt_r  <= 4'h0;
         lsh_r      <= 8'h00;
      end else if (!legacy_active) begin
         sync_cnt_r <= 4'h0;
         bit_cnt_r  <= 4'h0;
      end else if (vs_rise) begin
         if (sync_cnt_r != `DDC_SYNC_CLKS) begin
            sync_cnt_r <= sync_cnt_r + 4'h1; // RULE8
         end
         if (ddc1_load) begin
            lsh_r     <= ddc1_byte; // RULE7
            bit_cnt_r <= 4'h0;
         end else if (sync_cnt_r == `DDC_SYNC_CLKS) begin
            lsh_r     <= {lsh_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
      end
   end

   // two-wire slave state machine
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r     <= DDC_I_IDLE;
         bcnt_r   <= 4'h0;
         sh_r     <= 8'h00;
         rw_r     <= 1'b0;
         first_r  <= 1'b0;
         ack_r    <= 1'b0;
         sda_lo_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else if (!two_wire_enable) begin
         st_r     <= DDC_I_IDLE;
         sda_lo_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else if (i2c_start) begin
         st_r     <= DDC_I_ADDR;
         bcnt_r   <= 4'h0;
         sda_lo_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else if (i2c_stop) begin
         st_r     <= DDC_I_IDLE;
         sda_lo_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else begin
         case (st_r)
            DDC_I_ADDR, DDC_I_WDATA: begin
               if (scl_rise) begin
                  sh_r   <= {sh_r[6:0], sda_s2};
                  bcnt_r <= bcnt_r + 4'h1;
               end else if (scl_fall && bcnt_r == `DDC_I2C_BITS) begin
                  if (st_r == DDC_I_WDATA) begin
                     st_r     <= DDC_I_WHOLD;
                     scl_oe_r <= 1'b1; // RULE19
                  end else if (addr_hit(sh_r[7:1], any_address_match)) begin
                     st_r     <= DDC_I_ADDR_ACK;
                     rw_r     <= sh_r[0]; // RULE16
                     first_r  <= ~software_buffer_access;
                     sda_lo_r <= 1'b1;
                  end else begin
                     st_r <= DDC_I_IDLE;
                  end
               end
            end
            DDC_I_ADDR_ACK, DDC_I_WACK: begin
               if (scl_fall) begin
                  sda_lo_r <= 1'b0;
                  bcnt_r   <= 4'h0;
                  if (st_r == DDC_I_WACK) begin
                     first_r <= 1'b0;
                     st_r    <= DDC_I_WDATA; // RULE20
                  end else if (rw_r) begin
                     st_r     <= DDC_I_RLOAD;
                     scl_oe_r <= 1'b1; // RULE19
                  end else begin
                     st_r <= DDC_I_WDATA;
                  end
               end
            end
            DDC_I_WHOLD: begin
               if (whold_go) begin
                  st_r     <= DDC_I_WACK;
                  sda_lo_r <= 1'b1;
                  scl_oe_r <= 1'b0;
               end
            end
            DDC_I_RLOAD: begin
               if (rload_go) begin
                  sh_r     <= manual_mode ? data_r : mem_r[ptr_r]; // RULE4 RULE17
                  sda_lo_r <= manual_mode ? ~data_r[7] : ~mem_r[ptr_r][7];
                  bcnt_r   <= 4'h1;
                  st_r     <= DDC_I_RDATA;
                  scl_oe_r <= 1'b0;
               end
            end
            DDC_I_RDATA: begin
               if (scl_fall) begin
                  if (bcnt_r == `DDC_I2C_BITS) begin
                     sda_lo_r <= 1'b0;
                     st_r     <= DDC_I_RACK;
                  end else begin
                     sh_r     <= {sh_r[6:0], 1'b0};
                     sda_lo_r <= ~sh_r[6];
                     bcnt_r   <= bcnt_r + 4'h1;
                  end
               end
            end
            DDC_I_RACK: begin
               if (scl_rise) begin
                  ack_r <= ~sda_s2;
               end else if (scl_fall) begin
                  st_r     <= ack_r ? DDC_I_RLOAD : DDC_I_IDLE; // RULE20
                  scl_oe_r <= ack_r;
               end
            end
            default: begin
               st_r <= DDC_I_IDLE;
            end
         endcase
      end
   end

   // pin and status outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_oe_r  <= 1'b0;
         sda_out_r <= 1'b0;
         scl_out_r <= 1'b0;
         mapped_r  <= 1'b0; // RULE12
      end else begin
         if (legacy_active) begin
            sda_oe_r  <= (sync_cnt_r == `DDC_SYNC_CLKS) && (bit_cnt_r != `DDC_BIT_STOP); // RULE9
            sda_out_r <= lsh_r[7]; // RULE7
         end else begin
            sda_oe_r  <= sda_lo_r;
            sda_out_r <= 1'b0;
         end
         scl_out_r <= 1'b0;
         mapped_r  <= enabled | software_buffer_access; // RULE1 RULE2
      end
   end

   assign mcu_rdata              = rdata_r;
   assign buffer_address_pointer = ptr_r;
   assign two_wire_data_reg      = data_r;
   assign legacy_byte_irq_flag   = lirq_r;
   assign mode_switch_flag       = swf_r;
   assign byte_irq_flag          = birq_r;
   assign mode_ddc2              = mode2_r;
   assign buffer_space_mapped    = mapped_r;
   assign host_type              = host_r;
   assign scl_out                = scl_out_r;
   assign scl_oe                 = scl_oe_r;
   assign sda_out                = sda_out_r;
   assign sda_oe                 = sda_oe_r;

   // checks
   sequence s_ninth;
      legacy_active && manual_mode && vs_rise
         && sync_cnt_r == `DDC_SYNC_CLKS && bit_cnt_r == `DDC_BIT_STOP;
   endsequence
   sequence s_addr_ok;
      i2c_ev && st_r == DDC_I_ADDR && scl_fall && bcnt_r == `DDC_I2C_BITS
         && addr_hit(sh_r[7:1], any_address_match);
   endsequence

   property p_disabled_quiet;
      @(posedge clk) disable iff (!reset_n)
      !enabled ##1 !enabled |=> !sda_oe && !scl_oe && !byte_irq_flag && !legacy_byte_irq_flag;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("activity while disabled"); // RULE1
   property p_mapped;
      @(posedge clk) disable iff (!reset_n)
      1'b1 |=> buffer_space_mapped == $past(enabled | software_buffer_access);
   endproperty
   a_mapped: assert property (p_mapped) else $error("buffer space mapping wrong"); // RULE2
   property p_sync_release;
      @(posedge clk) disable iff (!reset_n)
      legacy_active && sync_cnt_r != `DDC_SYNC_CLKS |=> !sda_oe;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("sda driven in sync"); // RULE9
   property p_ninth_irq;
      @(posedge clk) disable iff (!reset_n)
      s_ninth |=> legacy_byte_irq_flag;
   endproperty
   a_ninth_irq: assert property (p_ninth_irq) else $error("legacy flag not set"); // RULE24
   property p_mode_sticky;
      @(posedge clk) disable iff (!reset_n)
      mode_ddc2 && enabled |=> mode_ddc2;
   endproperty
   a_mode_sticky: assert property (p_mode_sticky) else $error("mode left early"); // RULE22
   property p_switch_flag;
      @(posedge clk) disable iff (!reset_n)
      $rose(mode_ddc2) && $past(legacy_mode_enable) |-> mode_switch_flag;
   endproperty
   a_switch_flag: assert property (p_switch_flag) else $error("switch flag missing"); // RULE22
   property p_addr_ack;
      @(posedge clk) disable iff (!reset_n)
      s_addr_ok ##1 !i2c_start && !i2c_stop |=> sda_oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // RULE18
   property p_stretch_hold;
      @(posedge clk) disable iff (!reset_n)
      st_r == DDC_I_RLOAD && manual_mode && byte_irq_flag && i2c_ev |=> scl_oe;
   endproperty
   a_stretch_hold: assert property (p_stretch_hold) else $error("clock not held"); // RULE19
   property p_ptr_step;
      @(posedge clk) disable iff (!reset_n)
      mcu_ok && mcu_use_window && !ptr_load && !buffer_size_select && !ptr_r[7]
         && !legacy_active && st_r == DDC_I_IDLE
         |=> buffer_address_pointer == {1'b0, $past(ptr_r[6:0]) + 7'h01};
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong"); // RULE15
endmodule
`default_nettype wire

// ===== test/ddc_host_model.sv
// graphics host model: vsync clock, two-wire start and address bytes
`timescale 1ns/100ps
`default_nettype none
module ddc_host_model (
   // pins
   output logic vsync,
   output logic scl_drv,
   output logic sda_drv,
   // bus level seen by the host
   input  wire logic sda_in
);
   initial begin
      vsync = 1'b0;
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // vsync stands low between bursts, 64 ns period inside them
   task automatic vclk(input int n);
      // half a ns keeps every pin change off the bench clock rising edges
      #0.5;
      repeat (n) begin
         #32 vsync = 1'b1;
         #32 vsync = 1'b0;
      end
   endtask
   // data falls while clock is high
   task automatic start();
      #0.5 sda_drv = 1'b1;
      #100 scl_drv = 1'b1;
      #100 sda_drv = 1'b0;
      #100 scl_drv = 1'b0;
   endtask
   // one byte msb first, the ninth clock samples the acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv = b[i];
         #100 scl_drv = 1'b1;
         #100 scl_drv = 1'b0;
      end
      sda_drv = 1'b1;
      #100 scl_drv = 1'b1;
      #50 ack = ~sda_in;
      #50 scl_drv = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench of the display data channel slave
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic       clk = 0, reset_n = 0, le = 0, te = 0, swa = 0, req = 0;
   logic       we = 0, win = 0, pl = 0, clr = 0, bsz = 0, ax = 0, dl = 0, ak;
   logic [7:0] adr = 0, wd = 0, rd, ptr, dreg;
   logic       lf, mf, bf, m2, map, sclo, scle, sdao, sdae, vs, hs, hd;
   logic [1:0] ht;
   int         err_count = 0, checks = 0;
   // open-drain wires: host and slave pull low together
   wire        scl = hs & ~(scle & ~sclo);
   wire        sda = hd & ~(sdae & ~sdao);
   ddc_host_model h (.vsync(vs), .scl_drv(hs), .sda_drv(hd), .sda_in(sda));
   ddc_slave uut (.clk(clk), .reset_n(reset_n), .legacy_mode_enable(le),
      .two_wire_enable(te), .software_buffer_access(swa), .buffer_size_select(bsz),
      .any_address_match(ax), .mcu_req(req), .mcu_we(we), .mcu_use_window(win),
      .mcu_addr(adr), .mcu_wdata(wd), .mcu_rdata(rd), .ptr_load(pl), .ptr_wdata(wd),
      .buffer_address_pointer(ptr), .data_reg_load(dl), .data_reg_wdata(wd),
      .two_wire_data_reg(dreg), .legacy_irq_clear(clr), .mode_switch_clear(clr),
      .byte_irq_clear(clr), .legacy_byte_irq_flag(lf), .mode_switch_flag(mf),
      .byte_irq_flag(bf), .mode_ddc2(m2), .buffer_space_mapped(map), .host_type(ht),
      .vsync_pin(vs), .scl_in(scl), .sda_in(sda), .scl_out(sclo), .scl_oe(scle),
      .sda_out(sdao), .sda_oe(sdae));
   initial forever #2.5 clk = ~clk;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one software access; read data lands one cycle after the request
   task automatic acc(input logic wr, input logic u, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {we, win, adr, wd, req} <= {wr, u, a, d, 1'b1};
      w(1);
      req <= 1'b0;
      w(1);
   endtask
   task automatic pload(input logic [7:0] v);
      @(posedge clk);
      {pl, wd} <= {1'b1, v};
      w(1);
      pl <= 1'b0;
      w(1);
   endtask
   task automatic clear();
      @(posedge clk);
      clr <= 1'b1;
      w(1);
      clr <= 1'b0;
      w(2);
   endtask
   task automatic finish_test();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic t_buffer();
      w(1);
      chk("status", 8'h00, {m2, map, lf, mf, bf, sdae, scle, |ptr});
      acc(1, 1, 0, 8'h5a);
      chk("locked", 8'h00, {map, ptr[6:0]});
      swa <= 1'b1;
      pload(8'h7f);
      chk("map", 1, map);
      acc(1, 1, 0, 8'ha5);
      chk("wrap", 8'h00, ptr);
      acc(1, 0, 8'hc8, 8'h3c);
      acc(1, 0, 8'h00, 8'h81);
      pload(8'h7f);
      acc(0, 1, 0, 0);
      chk("rd", 8'ha5, rd);
      pload(8'hc8);
      acc(0, 1, 0, 0);
      chk("upper", 8'h3c, rd);
      chk("nostep", 8'hc8, ptr);
      bsz <= 1'b1;
      acc(0, 1, 0, 0);
      chk("big", 8'hc9, ptr);
      bsz <= 1'b0;
   endtask
   task automatic t_legacy();
      swa <= 1'b0;
      pload(8'h00);
      le <= 1'b1;
      h.vclk(8);
      w(8);
      chk("sync", 0, sdae);
      h.vclk(1);
      w(8);
      chk("bit7", 1, sdae & sdao);
      chk("auto", 8'h03, {map, ptr[0]});
      h.vclk(1);
      w(8);
      chk("bit6", 1, sdae & ~sdao);
   endtask
   task automatic t_manual();
      le <= 1'b0;
      swa <= 1'b1;
      w(3);
      {dl, wd} <= {1'b1, 8'h80};
      w(1);
      dl <= 1'b0;
      le <= 1'b1;
      h.vclk(18);
      w(8);
      chk("lirq", 1, lf);
      chk("dreg", 8'h81, {dreg[7:1], sdae & sdao});
      chk("host", 8'h01, {6'h00, ht});
      clear();
      chk("lirq", 0, lf);
      te <= 1'b1;
      h.start();
      w(8);
      chk("switch", 8'h03, {m2, mf});
      clear();
      chk("switch", 8'h02, {m2, mf});
      h.start();
      h.send(8'ha0, ak);
      chk("ack", 1, ak);
      w(1);
      h.start();
      h.send(8'ha6, ak);
      chk("nack", 0, ak);
      w(1);
      ax <= 1'b1;
      h.start();
      h.send(8'ha6, ak);
      chk("any", 1, ak);
      w(1);
      {le, te} <= 2'b00;
      w(4);
      chk("off", 8'h00, {m2, lf});
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_buffer();
      t_legacy();
      t_manual();
      finish_test();
   end
   // whole run needs some 10 us
   initial begin
      #100000;
      err_count++;
      finish_test();
   end
endmodule
`default_nettype wire
